// ==== can_mode_map.svh ====
`ifndef CAN_MODE_MAP_SVH
`define CAN_MODE_MAP_SVH

// ==========================================================================
// Register byte offsets on the register bus.
`define OFS_CONTROL_ONE   8'h00
`define OFS_CONFIG_TWO    8'h04
`define OFS_IRQ_ENABLE    8'h08
`define OFS_TX_CONTROL    8'h0C
`define OFS_BAUD          8'h10
`define OFS_ACC_FILTER    8'h14
`define OFS_ACC_MASK      8'h18
`define OFS_ERR_COUNT     8'h1C

// ==========================================================================
// Field positions.
`define REQ_OP_HI         10
`define REQ_OP_LO         8
`define CUR_OP_HI         7
`define CUR_OP_LO         5
`define WAKE_FILTER_BIT   14
`define TX_REQ_BIT        0
`define TX_ABORTED_BIT    1
`define WAKE_FLAG_BIT     2
`define IRQ_EN_MASK       8'hEF

// ==========================================================================
// Reset values.
`define CONFIG_RESET      16'h0000
`define IRQ_EN_RESET      8'h00

// ==========================================================================
// Timing.
`define IDLE_BITS         4'hB
`define CLK_PERIOD_NS     8
`define WAKE_FILTER_NS    200
`define WAKE_FILTER_CYC   ((`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== can_mode_pkg.sv ====
`default_nettype none
package can_mode_pkg;

  // ========================================================================
  // Operating modes, shared by the request and the status field.
  typedef enum logic [2:0] {
    OP_NORMAL      = 3'h0,
    OP_DISABLE     = 3'h1,
    OP_LOOPBACK    = 3'h2,
    OP_LISTEN_ONLY = 3'h3,
    OP_INIT        = 3'h4,
    OP_LISTEN_ALL  = 3'h7
  } op_mode_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_WAIT = 2'h1,
    TX_BUSY = 2'h2
  } tx_state_type;

  // ========================================================================
  // Mode decode.
  function automatic logic ownsTxPin(input op_mode_type m);
    return (m == OP_NORMAL) || (m == OP_LISTEN_ALL);
  endfunction

  function automatic logic ownsRxPin(input op_mode_type m);
    return (m == OP_NORMAL) || (m == OP_LISTEN_ALL) ||
           (m == OP_LISTEN_ONLY);
  endfunction

  function automatic logic mayTransmit(input op_mode_type m);
    return (m == OP_NORMAL) || (m == OP_LOOPBACK);
  endfunction

  function automatic logic isKnownMode(input logic [2:0] c);
    return (c == OP_NORMAL) || (c == OP_DISABLE) || (c == OP_LOOPBACK) ||
           (c == OP_LISTEN_ONLY) || (c == OP_INIT) ||
           (c == OP_LISTEN_ALL);
  endfunction

endpackage
`default_nettype wire

// ==== can_idle_detect.sv ====
`include "can_mode_map.svh"
`default_nettype none
module can_idle_detect (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic bitTick,
  input  wire logic rxBit,
  input  wire logic restart,
  output logic      busIdle
);

  logic [3:0] count_reg;
  logic [3:0] count_next;

  // ========================================================================
  // Saturating run of recessive bits; a dominant bit starts it over.
  always_comb begin
    count_next = count_reg;
    if (restart) begin
      count_next = 4'h0;
    end else if (bitTick) begin
      if (!rxBit) begin
        count_next = 4'h0;
      end else if (count_reg < `IDLE_BITS) begin
        count_next = count_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busIdle = (count_reg == `IDLE_BITS);

endmodule
`default_nettype wire

// ==== can_wake_filter.sv ====
`include "can_mode_map.svh"
`default_nettype none
module can_wake_filter (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic rawRx,
  input  wire logic filterOn,
  output logic      filtRx
);

  localparam logic [7:0] FILT_CYC = 8'(`WAKE_FILTER_CYC);

  logic       level_reg;
  logic       level_next;
  logic [7:0] run_reg;
  logic [7:0] run_next;

  // ========================================================================
  // Short glitches on the line must not wake a sleeping node, so a new
  // level is only taken after it has held for the whole filter time.
  always_comb begin
    level_next = level_reg;
    run_next   = 8'h00;
    if (!filterOn) begin
      level_next = rawRx;
    end else if (rawRx != level_reg) begin
      run_next = run_reg + 8'h01;
      if (run_next >= FILT_CYC) begin
        level_next = rawRx;
        run_next   = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_reg <= 1'b1;
      run_reg   <= 8'h00;
    end else begin
      level_reg <= level_next;
      run_reg   <= run_next;
    end
  end

  assign filtRx = level_reg;

endmodule
`default_nettype wire

// ==== can_operating_mode_control.sv ====
`include "can_mode_map.svh"
`default_nettype none
module can_operating_mode_control (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        canRxIn,
  output logic             canTxOut,
  output logic             canTxOe,
  output logic             rxPinIsCan,
  input  wire logic        gpioTxOut,
  input  wire logic        gpioTxOe,
  input  wire logic        cpuSleep,
  input  wire logic        bitTick,
  input  wire logic        coreTxBit,
  output logic             coreRxBit,
  input  wire logic        coreTxActive,
  input  wire logic        coreTxDone,
  input  wire logic        coreTxError,
  input  wire logic        coreRxError,
  output logic             txStart,
  output logic             txEnable,
  output logic             rxEnable,
  output logic             errAckEnable,
  output logic             copyAssembly,
  output logic [7:0]       irqEnables
);

  typedef can_mode_pkg::op_mode_type op_type;

  logic [2:0]   requested_op_field_reg, requested_op_field_next;
  op_type       curOp_reg, curOp_next;
  logic [15:0]  cfgTwo_reg, cfgTwo_next;
  logic [15:0]  baud_reg, baud_next;
  logic [15:0]  filt_reg, filt_next;
  logic [15:0]  mask_reg, mask_next;
  logic [7:0]   inte_reg, inte_next;
  logic         tx_request_bit_reg, tx_request_bit_next;
  logic         tx_aborted_flag_reg, tx_aborted_flag_next;
  logic         wake_reg, wake_next;
  logic [7:0]   txErr_reg, txErr_next;
  logic [7:0]   rxErr_reg, rxErr_next;
  can_mode_pkg::tx_state_type txState_reg, txState_next;
  logic         txStart_reg, txStart_next;
  logic         copy_reg, copy_next;
  logic         ack_reg, ack_next;
  logic [31:0]  dat_reg, dat_next;
  logic         prevRx_reg;
  logic         busIdle;
  logic         filtRx;
  logic         switchNow;
  logic         onLine;
  logic         wrEn;
  logic         cfgWrEn;
  logic         abortNow;
  logic         modeOk;

  // ========================================================================
  // Helpers.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction

  function automatic logic [7:0] satInc(input logic [7:0] v,
                                        input logic       hit);
    return (hit && v != 8'hFF) ? v + 8'h01 : v;
  endfunction

  // ========================================================================
  // Receive path and bus idle detection.
  can_wake_filter u_filter (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .rawRx    (canRxIn),
    .filterOn (cfgTwo_reg[`WAKE_FILTER_BIT] &&
               (cpuSleep || curOp_reg == can_mode_pkg::OP_DISABLE)),
    .filtRx   (filtRx)
  );

  can_idle_detect u_idle (
    .mclk    (mclk),
    .reset_n (reset_n),
    .bitTick (bitTick),
    .rxBit   (coreRxBit),
    .restart (switchNow),
    .busIdle (busIdle)
  );

  always_comb begin
    if (curOp_reg == can_mode_pkg::OP_LOOPBACK) begin
      coreRxBit = coreTxBit;
    end else if (curOp_reg == can_mode_pkg::OP_DISABLE) begin
      coreRxBit = filtRx;
    end else if (can_mode_pkg::ownsRxPin(curOp_reg)) begin
      coreRxBit = filtRx;
    end else begin
      coreRxBit = 1'b1;
    end
  end

  // ========================================================================
  // Pin hand-over. Anything not owned goes back to the port logic.
  assign canTxOut   = can_mode_pkg::ownsTxPin(curOp_reg) ? coreTxBit
                                                         : gpioTxOut;
  assign canTxOe    = can_mode_pkg::ownsTxPin(curOp_reg) ? 1'b1
                                                         : gpioTxOe;
  assign rxPinIsCan = can_mode_pkg::ownsRxPin(curOp_reg);
  assign txEnable   = can_mode_pkg::mayTransmit(curOp_reg);
  assign rxEnable   = (curOp_reg != can_mode_pkg::OP_INIT) &&
                      (curOp_reg != can_mode_pkg::OP_DISABLE);
  assign errAckEnable = can_mode_pkg::mayTransmit(curOp_reg);
  assign txStart    = txStart_reg;
  assign copyAssembly = copy_reg;
  assign irqEnables = inte_reg;

  // ========================================================================
  // Mode switching.
  assign onLine = (curOp_reg != can_mode_pkg::OP_INIT) &&
                  (curOp_reg != can_mode_pkg::OP_DISABLE);
  assign modeOk = can_mode_pkg::isKnownMode(requested_op_field_reg);
  assign switchNow = modeOk && (requested_op_field_reg != curOp_reg) &&
                     !(requested_op_field_reg == can_mode_pkg::OP_INIT &&
                       coreTxActive) &&
                     (!onLine || busIdle);

  always_comb begin
    curOp_next = curOp_reg;
    if (switchNow) begin
      curOp_next = op_type'(requested_op_field_reg);
    end
  end

  // ========================================================================
  // Transmit request sequencing.
  assign abortNow = (txState_reg == can_mode_pkg::TX_WAIT) &&
                    (requested_op_field_reg == can_mode_pkg::OP_DISABLE);

  always_comb begin
    txState_next = txState_reg;
    txStart_next = 1'b0;
    case (txState_reg)
      can_mode_pkg::TX_IDLE: begin
        if (tx_request_bit_reg && can_mode_pkg::mayTransmit(curOp_reg)) begin
          txState_next = can_mode_pkg::TX_WAIT;
        end
      end
      can_mode_pkg::TX_WAIT: begin
        if (abortNow || !can_mode_pkg::mayTransmit(curOp_reg) ||
            !tx_request_bit_reg) begin
          txState_next = can_mode_pkg::TX_IDLE;
        end else if (busIdle && !coreTxActive) begin
          txStart_next = 1'b1;
          txState_next = can_mode_pkg::TX_BUSY;
        end
      end
      can_mode_pkg::TX_BUSY: begin
        if (coreTxDone) begin
          txState_next = can_mode_pkg::TX_IDLE;
        end
      end
      default: begin
        txState_next = can_mode_pkg::TX_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Error counters and error handling.
  always_comb begin
    txErr_next = txErr_reg;
    rxErr_next = rxErr_reg;
    copy_next  = 1'b0;
    if (curOp_reg == can_mode_pkg::OP_INIT) begin
      txErr_next = 8'h00;
      rxErr_next = 8'h00;
    end else if (can_mode_pkg::mayTransmit(curOp_reg)) begin
      txErr_next = satInc(txErr_reg, coreTxError);
      rxErr_next = satInc(rxErr_reg, coreRxError);
    end
    if (curOp_reg == can_mode_pkg::OP_LISTEN_ALL) begin
      copy_next = coreRxError;
    end
  end

  // ========================================================================
  // Register bus. Reads are latched with the answer one cycle after the
  // request; writes land at the edge where the answer is seen.
  assign wrEn    = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign cfgWrEn = wrEn && !onLine &&
                   (curOp_reg == can_mode_pkg::OP_INIT);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_comb begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    dat_next = dat_reg;
    if (ack_next) begin
      case (wb_adr_i)
        `OFS_CONTROL_ONE: dat_next = {21'h0, requested_op_field_reg,
                                      curOp_reg, 5'h00};
        `OFS_CONFIG_TWO:  dat_next = {16'h0000, cfgTwo_reg};
        `OFS_IRQ_ENABLE:  dat_next = {24'h00_0000, inte_reg};
        `OFS_TX_CONTROL:  dat_next = {29'h0, wake_reg, tx_aborted_flag_reg,
                                      tx_request_bit_reg};
        `OFS_BAUD:        dat_next = {16'h0000, baud_reg};
        `OFS_ACC_FILTER:  dat_next = {16'h0000, filt_reg};
        `OFS_ACC_MASK:    dat_next = {16'h0000, mask_reg};
        `OFS_ERR_COUNT:   dat_next = {16'h0000, rxErr_reg, txErr_reg};
        default:          dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    requested_op_field_next  = requested_op_field_reg;
    cfgTwo_next = cfgTwo_reg;
    baud_next   = baud_reg;
    filt_next   = filt_reg;
    mask_next   = mask_reg;
    inte_next   = inte_reg;
    if (wrEn && wb_adr_i == `OFS_CONTROL_ONE && wb_sel_i[1]) begin
      requested_op_field_next = wb_dat_i[`REQ_OP_HI:`REQ_OP_LO];
    end
    if (cfgWrEn) begin
      case (wb_adr_i)
        `OFS_CONFIG_TWO: cfgTwo_next = merge16(cfgTwo_reg, wb_dat_i,
                                               wb_sel_i);
        `OFS_BAUD:       baud_next = merge16(baud_reg, wb_dat_i, wb_sel_i);
        `OFS_ACC_FILTER: filt_next = merge16(filt_reg, wb_dat_i, wb_sel_i);
        `OFS_ACC_MASK:   mask_next = merge16(mask_reg, wb_dat_i, wb_sel_i);
        `OFS_IRQ_ENABLE: begin
          if (wb_sel_i[0]) begin
            inte_next = wb_dat_i[7:0] & `IRQ_EN_MASK;
          end
        end
        default: begin
          inte_next = inte_reg;
        end
      endcase
    end
  end

  // Flags: a hardware set in the same cycle as a software clear wins.
  always_comb begin
    tx_request_bit_next = tx_request_bit_reg;
    tx_aborted_flag_next = tx_aborted_flag_reg;
    wake_next  = wake_reg;
    if (wrEn && wb_adr_i == `OFS_TX_CONTROL && wb_sel_i[0]) begin
      if (wb_dat_i[`TX_REQ_BIT]) begin
        tx_request_bit_next = 1'b1;
      end else if (txState_reg != can_mode_pkg::TX_BUSY) begin
        tx_request_bit_next = 1'b0;
      end
      if (wb_dat_i[`TX_ABORTED_BIT]) tx_aborted_flag_next = 1'b0;
      if (wb_dat_i[`WAKE_FLAG_BIT]) wake_next = 1'b0;
    end
    if (txState_reg == can_mode_pkg::TX_BUSY && coreTxDone) begin
      tx_request_bit_next = 1'b0;
    end
    if (abortNow) begin
      tx_request_bit_next = 1'b0;
      tx_aborted_flag_next = 1'b1;
    end
    if (curOp_reg == can_mode_pkg::OP_DISABLE && prevRx_reg && !filtRx) begin
      wake_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      requested_op_field_reg   <= can_mode_pkg::OP_INIT;
      curOp_reg   <= can_mode_pkg::OP_INIT;
      cfgTwo_reg  <= `CONFIG_RESET;
      baud_reg    <= `CONFIG_RESET;
      filt_reg    <= `CONFIG_RESET;
      mask_reg    <= `CONFIG_RESET;
      inte_reg    <= `IRQ_EN_RESET;
      tx_request_bit_reg   <= 1'b0;
      tx_aborted_flag_reg   <= 1'b0;
      wake_reg    <= 1'b0;
      txErr_reg   <= 8'h00;
      rxErr_reg   <= 8'h00;
      txState_reg <= can_mode_pkg::TX_IDLE;
      txStart_reg <= 1'b0;
      copy_reg    <= 1'b0;
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0000_0000;
      prevRx_reg  <= 1'b1;
    end else begin
      requested_op_field_reg   <= requested_op_field_next;
      curOp_reg   <= curOp_next;
      cfgTwo_reg  <= cfgTwo_next;
      baud_reg    <= baud_next;
      filt_reg    <= filt_next;
      mask_reg    <= mask_next;
      inte_reg    <= inte_next;
      tx_request_bit_reg   <= tx_request_bit_next;
      tx_aborted_flag_reg   <= tx_aborted_flag_next;
      wake_reg    <= wake_next;
      txErr_reg   <= txErr_next;
      rxErr_reg   <= rxErr_next;
      txState_reg <= txState_next;
      txStart_reg <= txStart_next;
      copy_reg    <= copy_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
      prevRx_reg  <= filtRx;
    end
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  status_follows_req_a: assert property (
    curOp_reg != $past(curOp_reg) |-> curOp_reg == $past(requested_op_field_reg))
    else $error("Mode changed to something not requested.");

  online_needs_idle_a: assert property (
    $past(onLine) && curOp_reg != $past(curOp_reg) |-> $past(busIdle))
    else $error("Active mode left without an idle bus.");

  init_not_in_tx_a: assert property (
    $past(coreTxActive) && $past(curOp_reg) != can_mode_pkg::OP_INIT
    |-> curOp_reg != can_mode_pkg::OP_INIT)
    else $error("Init mode entered during a transmission.");

  init_clears_counters_a: assert property (
    curOp_reg == can_mode_pkg::OP_INIT |=> txErr_reg == 8'h00 &&
    rxErr_reg == 8'h00)
    else $error("Error counters not cleared in init mode.");

  listen_freezes_count_a: assert property (
    curOp_reg == can_mode_pkg::OP_LISTEN_ONLY ##1
    curOp_reg == can_mode_pkg::OP_LISTEN_ONLY |-> $stable(txErr_reg) &&
    $stable(rxErr_reg))
    else $error("Error counters moved in listen-only mode.");

  disable_frees_pins_a: assert property (
    curOp_reg == can_mode_pkg::OP_DISABLE |-> canTxOe == gpioTxOe &&
    !rxPinIsCan && !txEnable)
    else $error("Pins kept by the controller in disable mode.");

  loopback_ties_a: assert property (
    curOp_reg == can_mode_pkg::OP_LOOPBACK |-> coreRxBit == coreTxBit &&
    !rxPinIsCan && canTxOut == gpioTxOut)
    else $error("Loopback path broken.");

  abort_in_wait_a: assert property (
    txState_reg == can_mode_pkg::TX_WAIT &&
    requested_op_field_reg == can_mode_pkg::OP_DISABLE |=> tx_aborted_flag_reg && !tx_request_bit_reg &&
    txState_reg == can_mode_pkg::TX_IDLE)
    else $error("Pending transmit not aborted.");

  start_after_idle_a: assert property (
    txStart_next |-> busIdle && can_mode_pkg::mayTransmit(curOp_reg))
    else $error("Transmit started without an idle bus.");

  config_locked_a: assert property (
    onLine ##1 onLine |-> $stable(cfgTwo_reg) && $stable(baud_reg) &&
    $stable(inte_reg))
    else $error("Configuration changed while on-line.");

  listen_all_copy_a: assert property (
    curOp_reg == can_mode_pkg::OP_LISTEN_ALL && coreRxError |=>
    copyAssembly)
    else $error("Partial frame not copied on error.");

endmodule
`default_nettype wire

// ==== can_bus_node.sv ====
`default_nettype none
module can_bus_node (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic dominant,
  input  wire logic devTxOut,
  input  wire logic devTxOe,
  output logic      busLevel,
  output logic      bitTick
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phaseReg;

  // ==========================================================================
  // Shared bus.
  // Wired-and: a dominant bit from any node overrides recessive.
  assign busLevel = !dominant && !(devTxOe && !devTxOut);

  // ==========================================================================
  // Bit timing.
  // Four clocks a bit keep the eleven-bit idle waits short in simulation.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phaseReg <= 2'h0;
      bitTick  <= 1'b0;
    end else begin
      phaseReg <= phaseReg + 2'h1;
      bitTick  <= (phaseReg == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`include "can_mode_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        canRx, canTxOut, canTxOe, rxPinIsCan, bitTick, coreRxBit;
  logic        txStart, txEnable, rxEnable, errAckEnable, copyAssembly;
  logic [7:0]  irqEnables;
  logic        dominant = 1'b0;
  logic        coreTxBit = 1'b1;
  logic        coreTxActive = 1'b0;
  logic        coreTxDone = 1'b0;
  logic        coreRxError = 1'b0;
  logic        coreTxError = 1'b0;
  int          miscompares = 0;
  int          checkCount = 0;

  always #4 mclk = ~mclk;

  can_operating_mode_control dut (
    .mclk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .canRxIn(canRx), .canTxOut, .canTxOe, .rxPinIsCan,
    .gpioTxOut(1'b1), .gpioTxOe(1'b0), .cpuSleep(1'b0), .bitTick,
    .coreTxBit, .coreRxBit, .coreTxActive, .coreTxDone,
    .coreTxError, .coreRxError, .txStart, .txEnable, .rxEnable,
    .errAckEnable, .copyAssembly, .irqEnables
  );

  can_bus_node node (
    .mclk, .reset_n, .dominant, .devTxOut(canTxOut), .devTxOe(canTxOe),
    .busLevel(canRx), .bitTick
  );

  // ==========================================================================
  // Shared tasks.
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // The slave answer time is never assumed; only the bound cuts a hang.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    if (n >= 20) begin
      chk("ack", 32'h0, 32'h1);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] m, exp);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(what, rd & m, exp);
  endtask

  task automatic mode(input logic [2:0] c);
    wb(1'b1, `OFS_CONTROL_ONE, {21'h00_0000, c, 8'h00}, 4'h2);
  endtask

  task automatic chkMode(input logic [2:0] c);
    rchk("mode", `OFS_CONTROL_ONE, 32'h0000_00E0, {24'h00_0000, c, 5'h00});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_init();
    chkMode(can_mode_pkg::OP_INIT);
    rchk("irq en", `OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("unmapped", 8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    mode(3'h5);
    chkMode(can_mode_pkg::OP_INIT);
    wb(1'b1, `OFS_IRQ_ENABLE, 32'h0000_FFFF, 4'h3);
    rchk("irq en", `OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_00EF);
    chk("irq port", 32'(irqEnables), 32'h0000_00EF);
    chk("rx enable", 32'(rxEnable), 32'h0000_0000);
    chk("tx enable", 32'(txEnable), 32'h0000_0000);
    wb(1'b1, `OFS_CONFIG_TWO, 32'h0000_4000, 4'h2);
    rchk("cfg two", `OFS_CONFIG_TWO, 32'hFFFF_FFFF, 32'h0000_4000);
    $display("init test done");
  endtask

  task automatic t_listen();
    mode(can_mode_pkg::OP_LISTEN_ONLY);
    chkMode(can_mode_pkg::OP_LISTEN_ONLY);
    chk("tx oe", 32'(canTxOe), 32'h0000_0000);
    chk("err ack", 32'(errAckEnable), 32'h0000_0000);
    chk("tx en", 32'(txEnable), 32'h0000_0000);
    mode(can_mode_pkg::OP_NORMAL);
    idle(60);
    chkMode(can_mode_pkg::OP_NORMAL);
    chk("tx oe", 32'(canTxOe), 32'h0000_0001);
    chk("rx pin", 32'(rxPinIsCan), 32'h0000_0001);
    chk("tx en", 32'(txEnable), 32'h0000_0001);
    wb(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0000, 4'h3);
    rchk("locked", `OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_00EF);
    $display("listen test done");
  endtask

  task automatic t_disable();
    dominant <= 1'b1;
    mode(can_mode_pkg::OP_DISABLE);
    idle(80);
    chkMode(can_mode_pkg::OP_NORMAL);
    dominant <= 1'b0;
    idle(60);
    chkMode(can_mode_pkg::OP_DISABLE);
    chk("tx oe", 32'(canTxOe), 32'h0000_0000);
    chk("rx pin", 32'(rxPinIsCan), 32'h0000_0000);
    // A glitch shorter than the filter time must not wake the node.
    dominant <= 1'b1;
    idle(4);
    dominant <= 1'b0;
    idle(4);
    rchk("glitch", `OFS_TX_CONTROL, 32'h0000_0004, 32'h0000_0000);
    dominant <= 1'b1;
    idle(40);
    dominant <= 1'b0;
    idle(40);
    rchk("wake", `OFS_TX_CONTROL, 32'h0000_0004, 32'h0000_0004);
    $display("disable test done");
  endtask

  task automatic t_abort();
    mode(can_mode_pkg::OP_LOOPBACK);
    chkMode(can_mode_pkg::OP_LOOPBACK);
    coreTxBit <= 1'b0;
    idle(1);
    chk("loop rx", 32'(coreRxBit), 32'h0000_0000);
    chk("tx oe", 32'(canTxOe), 32'h0000_0000);
    coreTxBit <= 1'b1;
    wb(1'b1, `OFS_TX_CONTROL, 32'h0000_0001, 4'h1);
    mode(can_mode_pkg::OP_DISABLE);
    idle(2);
    rchk("abort", `OFS_TX_CONTROL, 32'h0000_0003, 32'h0000_0002);
    idle(60);
    chkMode(can_mode_pkg::OP_DISABLE);
    $display("abort test done");
  endtask

  task automatic t_tx();
    int n;
    int k;
    n = 0;
    k = 0;
    mode(can_mode_pkg::OP_NORMAL);
    wb(1'b1, `OFS_TX_CONTROL, 32'h0000_0003, 4'h1);
    while (txStart !== 1'b1 && k < 100) begin
      @(posedge mclk);
      if (bitTick === 1'b1) n++;
      k++;
    end
    chk("start", 32'(k < 100), 32'h0000_0001);
    chk("idle bits", 32'(n >= 10), 32'h0000_0001);
    coreTxDone <= 1'b1;
    @(posedge mclk);
    coreTxDone <= 1'b0;
    rchk("tx req", `OFS_TX_CONTROL, 32'h0000_0001, 32'h0000_0000);
    coreTxError <= 1'b1;
    coreRxError <= 1'b1;
    @(posedge mclk);
    coreTxError <= 1'b0;
    coreRxError <= 1'b0;
    rchk("err cnt", `OFS_ERR_COUNT, 32'hFFFF_FFFF, 32'h0000_0101);
    $display("transmit test done");
  endtask

  task automatic t_all();
    mode(can_mode_pkg::OP_LISTEN_ALL);
    idle(60);
    chkMode(can_mode_pkg::OP_LISTEN_ALL);
    chk("err ack", 32'(errAckEnable), 32'h0000_0000);
    coreRxError <= 1'b1;
    @(posedge mclk);
    coreRxError <= 1'b0;
    @(posedge mclk);
    chk("copy", 32'(copyAssembly), 32'h0000_0001);
    rchk("err held", `OFS_ERR_COUNT, 32'hFFFF_FFFF, 32'h0000_0101);
    coreTxActive <= 1'b1;
    mode(can_mode_pkg::OP_INIT);
    idle(80);
    chkMode(can_mode_pkg::OP_LISTEN_ALL);
    coreTxActive <= 1'b0;
    idle(60);
    chkMode(can_mode_pkg::OP_INIT);
    rchk("err cnt", `OFS_ERR_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("flags kept", `OFS_TX_CONTROL, 32'h0000_0004, 32'h0000_0004);
    $display("listen all test done");
  endtask

  // ==========================================================================
  // Sequence and watchdog.
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_init();
    t_listen();
    t_disable();
    t_abort();
    t_tx();
    t_all();
    end_sim();
  end

  // The tests need some eight hundred cycles; twenty thousand cycles is a hang.
  initial begin
    #160_000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
